/* hdl/tdmp_cfg.svh */
`ifndef TDMP_CFG_SVH
`define TDMP_CFG_SVH

`define TDMP_BUS_CLK_KHZ      4096
`define TDMP_FRAME_KHZ        8
`define TDMP_FRAME_LCLKS      (`TDMP_BUS_CLK_KHZ / `TDMP_FRAME_KHZ)
`define TDMP_CNT_W            9
`define TDMP_LAST_LCLK        9'h1FF
`define TDMP_CHANNELS         32
`define TDMP_BITS_PER_CHAN    8
`define TDMP_LCLKS_PER_BIT    2
`define TDMP_T1_FRAME_BITS    193
`define TDMP_T1_PAYLOAD_BITS  192
`define TDMP_T1_SLOTS         5'h18
`define TDMP_ISDN_GROUPED_CH  5'h17
`define TDMP_ISDN_SPACED_CH   5'h1F
`define TDMP_E1_FRAMING_CH    5'h00
`define TDMP_E1_SIGNAL_CH     5'h10
`define TDMP_NUM_RX_CLOCKS    4'h8
`define TDMP_NUM_REF_CLOCKS   4'h4
`define TDMP_CHAN_START       4'h0
`define TDMP_CHAN_LAST_SAMPLE 4'hF

`endif

/* hdl/tdmp_pkg.sv */
package tdmp_pkg;
    typedef logic [4:0] tdmp_chan_t;
    typedef logic [3:0] tdmp_src_t;
    typedef logic [8:0] tdmp_count_t;
endpackage

/* hdl/tdmp_sync_edge.sv */
`timescale 1ns/100ps
module tdmp_sync_edge (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      level,
    output logic      rise
);
    logic meta;
    logic last;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta  <= 1'b0;
            level <= 1'b0;
            last  <= 1'b0;
        end else begin
            meta  <= async_in;
            level <= meta;
            last  <= level;
        end
    end

    assign rise = level & ~last;
endmodule

/* hdl/tdmp_port.sv */
// Overview of operation
// R1: T1 bus mode: external timing takes tx clock and pulse in; internal drives them.
// R2: Receive bit clock and frame pulse are always inputs from the framer.
// R3: A T1 frame is one framing bit plus 24 timeslots of 8 bits.
// R4: Bus frame has 32 channels; a setting picks T1 spaced or grouped mapping.
// R5: Spaced mapping leaves every fourth channel from 0 empty; timeslots fill the rest.
// R6: Grouped mapping puts timeslots 1 to 24 on channels 0 to 23.
// R7: Transmit data is high impedance in every unused channel.
// R8: Bus clock is 4.096 MHz with an 8 kHz frame pulse.
// R9: Internal tx clock comes from one of eight receive or four reference clocks.
// R10: The selected source must already be a valid 4.096 MHz bus clock.
// R11: Generated tx frame pulse derives from tx clock, independent of other pulses.
// R12: ISDN option drops T1 timeslot 24 on both directions.
// R13: E1 uses 30 channels, skipping channels 0 and 16.
// R14: E1 bus mode: external timing takes tx clock and pulse in; internal drives them.
// R15: One direction bit turns tx clock and pulse between input and output.
// R16: A pulse at an unexpected frame time sets a sticky error and realigns.
// R17: Bits go most significant first; the pulse marks the start of channel 0.
`timescale 1ns/100ps
`include "tdmp_cfg.svh"
module tdmp_port (
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               link_is_e1,
    input  wire logic               t1_grouped,
    input  wire logic               t1_isdn,
    input  wire logic               tx_timing_internal,
    input  wire tdmp_pkg::tdmp_src_t tx_clock_select,
    input  wire logic [7:0]         rx_bit_clock_pool,
    input  wire logic [3:0]         external_ref_clock,
    input  wire logic               rx_bit_clock,
    input  wire logic               rx_frame_pulse_n,
    input  wire logic               serial_rx_data,
    input  wire logic               tx_bit_clock_in,
    input  wire logic               tx_frame_pulse_n_in,
    input  wire logic [7:0]         tx_byte,
    input  wire logic               sync_error_clear,
    output logic                    tx_bit_clock_out,
    output logic                    tx_bit_clock_oe,
    output logic                    tx_frame_pulse_n_out,
    output logic                    tx_frame_pulse_n_oe,
    output logic                    serial_tx_data_out,
    output logic                    serial_tx_data_oe,
    output logic                    tx_byte_take,
    output logic [7:0]              rx_byte,
    output logic                    rx_byte_valid,
    output logic                    rx_sync_error,
    output logic                    tx_sync_error
);
    import tdmp_pkg::*;

    // True when the channel carries payload under the current mapping.
    function automatic logic chan_used(input tdmp_chan_t ch, input logic e1,
                                       input logic grouped, input logic isdn);
        logic e1_used;
        logic grouped_used;
        logic spaced_used;
        logic isdn_slot;
        e1_used      = (ch != `TDMP_E1_FRAMING_CH) && (ch != `TDMP_E1_SIGNAL_CH); // [R13]
        grouped_used = ch < `TDMP_T1_SLOTS; // [R6]
        spaced_used  = ch[1:0] != 2'h0; // [R5]
        // Timeslot 24 sits on a different channel in each T1 mapping.
        isdn_slot    = grouped ? (ch == `TDMP_ISDN_GROUPED_CH) : (ch == `TDMP_ISDN_SPACED_CH);
        if (e1) begin
            return e1_used;
        end
        if (isdn && isdn_slot) begin
            return 1'b0; // [R12]
        end
        return grouped ? grouped_used : spaced_used;
    endfunction

    // Next frame position: a low pulse seen at an edge makes that same edge position 0 of the frame.
    function automatic tdmp_count_t next_count(input tdmp_count_t cnt, input logic fp_low);
        return fp_low ? '0 : tdmp_count_t'(cnt + 9'h001); // [R8] [R17]
    endfunction

    wire src_is_rx  = tx_clock_select < `TDMP_NUM_RX_CLOCKS;
    wire src_is_ref = tx_clock_select < (`TDMP_NUM_RX_CLOCKS + `TDMP_NUM_REF_CLOCKS);
    // The source must itself run at the bus rate; there is no synthesis here.
    wire src_raw    = src_is_rx  ? rx_bit_clock_pool[tx_clock_select[2:0]] :
                      src_is_ref ? external_ref_clock[tx_clock_select[1:0]] : 1'b0; // [R9] [R10]

    logic sel_level, sel_rise, txc_rise, txf_level, rxc_rise, rxf_level, rxd_level;

    tdmp_sync_edge u_sel (.core_clk(core_clk), .reset(reset), .async_in(src_raw),
                          .level(sel_level), .rise(sel_rise));
    tdmp_sync_edge u_txc (.core_clk(core_clk), .reset(reset), .async_in(tx_bit_clock_in),
                          .level(), .rise(txc_rise));
    tdmp_sync_edge u_txf (.core_clk(core_clk), .reset(reset), .async_in(tx_frame_pulse_n_in),
                          .level(txf_level), .rise());
    tdmp_sync_edge u_rxc (.core_clk(core_clk), .reset(reset), .async_in(rx_bit_clock),
                          .level(), .rise(rxc_rise)); // [R2]
    tdmp_sync_edge u_rxf (.core_clk(core_clk), .reset(reset), .async_in(rx_frame_pulse_n),
                          .level(rxf_level), .rise()); // [R2]
    tdmp_sync_edge u_rxd (.core_clk(core_clk), .reset(reset), .async_in(serial_rx_data),
                          .level(rxd_level), .rise());

    tdmp_count_t tx_cnt;
    tdmp_count_t rx_cnt;
    logic        tx_locked;
    logic        rx_locked;
    logic [7:0]  tx_shift;
    logic [6:0]  rx_shift;

    // Direction bit selects which clock and pulse time the transmit side.
    wire tx_edge   = tx_timing_internal ? sel_rise : txc_rise; // [R1] [R14] [R15]
    wire tx_fp_low = tx_timing_internal ? ~tx_frame_pulse_n_out : ~txf_level; // [R11]
    wire tx_misfit = ~tx_timing_internal && tx_fp_low && tx_locked
                     && (tx_cnt != `TDMP_LAST_LCLK); // [R16]
    wire rx_fp_low = ~rxf_level;
    wire rx_misfit = rx_fp_low && rx_locked && (rx_cnt != `TDMP_LAST_LCLK); // [R16]

    wire tdmp_count_t next_tx_cnt = next_count(tx_cnt, tx_fp_low);
    wire tdmp_count_t next_rx_cnt = next_count(rx_cnt, rx_fp_low);
    wire tdmp_chan_t  tx_chan     = next_tx_cnt[8:4];
    wire tdmp_chan_t  rx_chan     = next_rx_cnt[8:4];
    wire tx_used = chan_used(tx_chan, link_is_e1, t1_grouped, t1_isdn); // [R4]
    wire rx_used = chan_used(rx_chan, link_is_e1, t1_grouped, t1_isdn); // [R4] [R3]
    wire tx_chan_start = next_tx_cnt[3:0] == `TDMP_CHAN_START;
    wire tx_bit_start  = ~next_tx_cnt[0];
    wire rx_mid_bit    = next_rx_cnt[0];
    wire rx_chan_end   = next_rx_cnt[3:0] == `TDMP_CHAN_LAST_SAMPLE;

    // Regenerated clock: a synchronised copy of the source, so it lags the source slightly.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_bit_clock_out <= 1'b0;
        end else begin
            tx_bit_clock_out <= tx_timing_internal & sel_level; // [R9]
        end
    end

    // Pin directions follow the direction bit one cycle late.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_bit_clock_oe     <= 1'b0;
            tx_frame_pulse_n_oe <= 1'b0;
        end else begin
            tx_bit_clock_oe     <= tx_timing_internal; // [R1] [R14] [R15]
            tx_frame_pulse_n_oe <= tx_timing_internal; // [R1] [R14] [R15]
        end
    end

    // Transmit framing and serialiser.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_cnt               <= `TDMP_LAST_LCLK;
            tx_locked            <= 1'b0;
            tx_frame_pulse_n_out <= 1'b1;
            tx_shift             <= 8'h00;
            serial_tx_data_out   <= 1'b0;
            serial_tx_data_oe    <= 1'b0;
            tx_byte_take         <= 1'b0;
        end else begin
            tx_byte_take <= 1'b0;
            if (tx_edge) begin
                tx_cnt <= next_tx_cnt;
                if (tx_fp_low) begin
                    tx_locked <= 1'b1;
                end
                // Free running from the chosen clock, never tied to receive timing.
                tx_frame_pulse_n_out <= ~(tx_timing_internal
                                          && next_tx_cnt == `TDMP_LAST_LCLK); // [R11]
                if (tx_chan_start) begin
                    serial_tx_data_oe <= tx_used; // [R7] [R12]
                    if (tx_used) begin
                        tx_shift           <= tx_byte;
                        serial_tx_data_out <= tx_byte[7]; // [R17]
                        tx_byte_take       <= 1'b1;
                    end
                end else if (tx_bit_start) begin
                    tx_shift           <= {tx_shift[6:0], 1'b0};
                    serial_tx_data_out <= tx_shift[6]; // [R17]
                end
            end
            if (!tx_timing_internal) begin
                // A flip to external timing must not leave a generated low pulse standing.
                tx_frame_pulse_n_out <= 1'b1; // [R1] [R14]
            end
        end
    end

    // Receive framing and deserialiser.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_cnt        <= `TDMP_LAST_LCLK;
            rx_locked     <= 1'b0;
            rx_shift      <= 7'h00;
            rx_byte       <= 8'h00;
            rx_byte_valid <= 1'b0;
        end else begin
            rx_byte_valid <= 1'b0;
            if (rxc_rise) begin
                rx_cnt <= next_rx_cnt; // [R16]
                if (rx_fp_low) begin
                    rx_locked <= 1'b1;
                end
                if (rx_mid_bit) begin
                    rx_shift <= {rx_shift[5:0], rxd_level}; // [R17]
                    if (rx_chan_end && rx_used) begin
                        rx_byte       <= {rx_shift, rxd_level};
                        rx_byte_valid <= 1'b1; // [R12] [R13]
                    end
                end
            end
        end
    end

    // Sticky errors; a new misfit in the clearing cycle wins over the clear.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_sync_error <= 1'b0;
            tx_sync_error <= 1'b0;
        end else begin
            rx_sync_error <= (rx_sync_error & ~sync_error_clear) | (rxc_rise & rx_misfit); // [R16]
            tx_sync_error <= (tx_sync_error & ~sync_error_clear) | (tx_edge & tx_misfit); // [R16]
        end
    end
endmodule

/* bench/tdmp_port_asserts.sv */
`timescale 1ns/100ps
module tdmp_port_asserts (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       tx_timing_internal,
    input wire logic [7:0] tx_byte,
    input wire logic       sync_error_clear,
    input wire logic       tx_bit_clock_out,
    input wire logic       tx_bit_clock_oe,
    input wire logic       tx_frame_pulse_n_out,
    input wire logic       tx_frame_pulse_n_oe,
    input wire logic       serial_tx_data_out,
    input wire logic       serial_tx_data_oe,
    input wire logic       tx_byte_take,
    input wire logic       rx_byte_valid,
    input wire logic       rx_sync_error,
    input wire logic       tx_sync_error
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence ext_held; !tx_timing_internal [*4]; endsequence
    sequence take_quiet; !tx_byte_take [*8]; endsequence
    sequence rx_quiet; !rx_byte_valid [*8]; endsequence
    oe_pair_a: assert property (tx_bit_clock_oe == tx_frame_pulse_n_oe)
        else $error("tx clock and pulse enables differ");
    dir_follow_a: assert property (!$past(reset) |-> tx_bit_clock_oe == $past(tx_timing_internal))
        else $error("tx clock enable does not follow direction");
    ext_idle_a: assert property (ext_held |-> !tx_bit_clock_oe && !tx_bit_clock_out && tx_frame_pulse_n_out)
        else $error("tx clock or pulse active with external timing");
    take_gap_a: assert property (tx_byte_take |=> take_quiet)
        else $error("byte loads too close");
    valid_gap_a: assert property (rx_byte_valid |=> rx_quiet)
        else $error("received bytes too close");
    take_msb_a: assert property (tx_byte_take |-> serial_tx_data_oe && serial_tx_data_out == $past(tx_byte[7]))
        else $error("load does not start msb first");
    rx_err_hold_a: assert property (rx_sync_error && !sync_error_clear |=> rx_sync_error)
        else $error("rx sync error lost");
    tx_err_hold_a: assert property (tx_sync_error && !sync_error_clear |=> tx_sync_error)
        else $error("tx sync error lost");
endmodule
bind tdmp_port tdmp_port_asserts u_tdmp_port_asserts (.core_clk(core_clk), .reset(reset),
    .tx_timing_internal(tx_timing_internal), .tx_byte(tx_byte), .sync_error_clear(sync_error_clear),
    .tx_bit_clock_out(tx_bit_clock_out), .tx_bit_clock_oe(tx_bit_clock_oe),
    .tx_frame_pulse_n_out(tx_frame_pulse_n_out), .tx_frame_pulse_n_oe(tx_frame_pulse_n_oe),
    .serial_tx_data_out(serial_tx_data_out), .serial_tx_data_oe(serial_tx_data_oe),
    .tx_byte_take(tx_byte_take), .rx_byte_valid(rx_byte_valid), .rx_sync_error(rx_sync_error),
    .tx_sync_error(tx_sync_error));

/* bench/tdmp_framer_model.sv */
`timescale 1ns/100ps
module tdmp_framer_model (
    input  wire logic  skip,
    output logic       bit_clock,
    output logic       frame_pulse_n,
    output logic       data,
    output logic [8:0] pos
);
    wire [7:0] pattern = {3'h5, pos[8:4]};
    // Lines change on the falling edge so they are steady when the device samples them.
    initial begin
        bit_clock = 1'b0;
        frame_pulse_n = 1'b1;
        data = 1'b0;
        pos = 9'h1F0;
        #13;
        forever #160 bit_clock = ~bit_clock;
    end
    always @(posedge bit_clock) pos <= skip ? pos + 9'h064 : pos + 9'h001;
    always @(negedge bit_clock) begin
        frame_pulse_n <= (pos != 9'h1FF);
        data <= pattern[3'h7 - pos[3:1]];
    end
endmodule

/* bench/tdmp_port_tb.sv */
`timescale 1ns/100ps
module tdmp_port_tb;
    import tdmp_pkg::*;
    logic       core_clk, reset, e1, grp, isdn, tint, clr, skip, chk, fck, fpn, fd;
    logic       tck, tck_oe, tfp, tfp_oe, sd, sd_oe, take, rxv, rx_err, tx_err;
    logic [7:0] tx_byte, rx_byte;
    logic [8:0] pos;
    logic [11:0] mask;
    tdmp_src_t  sel;
    int         fails, n_compared, n_take, n_rxv;
    wire [11:0] srcs = ({12{fck}} & mask) | ({12{~fck}} & ~mask);
    tdmp_framer_model u_tdmp_framer_model (.skip(skip), .bit_clock(fck), .frame_pulse_n(fpn),
        .data(fd), .pos(pos));
    tdmp_port u_tdmp_port (.core_clk(core_clk), .reset(reset), .link_is_e1(e1), .t1_grouped(grp),
        .t1_isdn(isdn), .tx_timing_internal(tint), .tx_clock_select(sel),
        .rx_bit_clock_pool(srcs[7:0]), .external_ref_clock(srcs[11:8]), .rx_bit_clock(fck),
        .rx_frame_pulse_n(fpn), .serial_rx_data(fd), .tx_bit_clock_in(fck),
        .tx_frame_pulse_n_in(fpn), .tx_byte(tx_byte), .sync_error_clear(clr),
        .tx_bit_clock_out(tck), .tx_bit_clock_oe(tck_oe), .tx_frame_pulse_n_out(tfp),
        .tx_frame_pulse_n_oe(tfp_oe), .serial_tx_data_out(sd), .serial_tx_data_oe(sd_oe),
        .tx_byte_take(take), .rx_byte(rx_byte), .rx_byte_valid(rxv), .rx_sync_error(rx_err),
        .tx_sync_error(tx_err));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic used(input logic [4:0] ch);
        if (e1) return ch != 5'h00 && ch != 5'h10;
        if (grp) return ch < 5'h18 && !(isdn && ch == 5'h17);
        return ch[1:0] != 2'h0 && !(isdn && ch == 5'h1F);
    endfunction
    task automatic next_edge();
        logic [8:0] p;
        int n;
        p = pos;
        for (n = 0; n < 12 && pos === p; n++) @(posedge core_clk);
        if (pos === p) begin
            fails++;
            give_verdict();
        end
    endtask
    always @(posedge core_clk) begin
        if (take) n_take++;
        if (rxv) n_rxv++;
        if (rxv && chk) check("rx byte", rx_byte, {4'h0, 3'h5, pos[8:4]});
    end
    task automatic run_frame(input logic ve1, vgrp, visdn, input logic [8:0] n_used);
        int i;
        e1 <= ve1;
        grp <= vgrp;
        isdn <= visdn;
        for (i = 0; i < 4200 && pos !== 9'h1FF; i++) @(posedge core_clk);
        next_edge();
        chk = 1'b1;
        n_take = 0;
        n_rxv = 0;
        for (i = 0; i < 512; i++) begin
            if (!pos[0]) begin
                repeat (6) @(posedge core_clk);
                check("tx enable", sd_oe, used(pos[8:4]));
                if (used(pos[8:4])) check("tx bit", sd, tx_byte[3'h7 - pos[3:1]]);
            end
            next_edge();
        end
        chk = 1'b0;
        check("loads", 9'(n_take), n_used);
        check("rx bytes", 9'(n_rxv), n_used);
        $display("frame test done");
    endtask
    task automatic sync_slip();
        int i;
        clr <= 1'b1;
        repeat (2) @(posedge core_clk);
        clr <= 1'b0;
        skip <= 1'b1;
        next_edge();
        skip <= 1'b0;
        check("errors clear", {rx_err, tx_err}, 9'h000);
        for (i = 0; i < 4200 && {rx_err, tx_err} !== 2'h3; i++) @(posedge core_clk);
        check("errors set", {rx_err, tx_err}, 9'h003);
        run_frame(1'b1, 1'b0, 1'b0, 9'h01E);
        $display("sync slip test done");
    endtask
    task automatic clock_src();
        int s;
        int lows;
        tint <= 1'b1;
        for (s = 0; s < 12; s++) begin
            sel <= s[3:0];
            mask <= 12'h001 << s;
            repeat (12) @(posedge core_clk);
            next_edge();
            repeat (4) @(posedge core_clk);
            check("tx clock high", tck, 9'h001);
            repeat (4) @(posedge core_clk);
            check("tx clock low", tck, 9'h000);
            check("tx enables", {tck_oe, tfp_oe}, 9'h003);
        end
        lows = 0;
        repeat (4096) begin
            @(posedge core_clk);
            lows += !tfp;
        end
        check("pulse width", 9'(lows), 9'h008);
        tint <= 1'b0;
        repeat (8) @(posedge core_clk);
        check("tx enables off", {tck_oe, tfp_oe, tck}, 9'h000);
        $display("clock source test done");
    endtask
    initial begin
        {reset, e1, grp, isdn, tint, clr, skip, chk, sel, mask} = {1'b1, 23'h0};
        tx_byte = 8'h1D;
        fails = 0;
        n_compared = 0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        run_frame(1'b1, 1'b0, 1'b0, 9'h01E);
        run_frame(1'b0, 1'b0, 1'b0, 9'h018);
        run_frame(1'b0, 1'b1, 1'b0, 9'h018);
        run_frame(1'b0, 1'b0, 1'b1, 9'h017);
        run_frame(1'b0, 1'b1, 1'b1, 9'h017);
        sync_slip();
        clock_src();
        give_verdict();
    end
endmodule
